// ---- dpl_loops.sv ----
// Purpose: Amplitude and phase PI loops for a lever oscillator, Avalon-MM
//    register slave, setpoint modulation and frequency shift report.
// Assumes: Lock-in and converter samples arrive on i_clk already.
// Notes: Answer to every access comes one cycle after it is seen.
// Function
// - Each enabled loop keeps its output between its programmed minimum and maximum.
// - A set polarity inversion flips the sign of that loop's error.
// - Each loop raises its activity output while enabled and running.
// - The amplitude loop regulates the lock-in amplitude by driving excitation amplitude.
// - The phase loop measures either the lock-in phase or one converter channel, by selector.
// - All other loop inputs and outputs are wired fixed.
// - With gain lock set, writing one gain rescales the other to keep their ratio.
// - With modulation on, the setpoint toggles between normal and alternate each period.
// - Each loop has its own independent setpoint modulation.
// - While the phase loop runs the reported frequency shift follows its output.
// - A disabled loop drives its fixed excitation setting.
// - The phase loop regulates only once its enable is set.
// - The frequency shift also feeds the z controller input.
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module dpl_loops
   import dpl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Avalon-MM slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Demodulator and converter samples
   input wire logic signed [DW-1:0] i_lockin_amplitude,
   input wire logic signed [DW-1:0] i_lockin_phase,
   input wire logic [NADC-1:0][DW-1:0] i_adc,
   // Excitation generator and z controller
   output logic signed [DW-1:0] o_excitation_amplitude,
   output logic signed [DW-1:0] o_excitation_frequency,
   output logic signed [DW-1:0] o_frequency_shift,
   output logic o_amp_active,
   output logic o_phase_active
);
   typedef struct packed {
      dpl_bus_t bus;
      logic [31:0] rdata;
      logic [CW-1:0] ctrl;
      logic [NL-1:0][DW-1:0] mn;
      logic [NL-1:0][DW-1:0] mx;
      logic [NL-1:0][GW-1:0] kp;
      logic [NL-1:0][GW-1:0] ki;
      logic [NL-1:0][DW-1:0] sp;
      logic [NL-1:0][DW-1:0] alt;
      logic [NL-1:0][PW-1:0] per;
      logic [NL-1:0][PW-1:0] cnt;
      logic [NL-1:0][DW-1:0] fix;
      logic [NL-1:0] alt_on;
      logic [DW-1:0] fshift;
   } dpl_st_t;

   dpl_st_t s_q;
   dpl_st_t s_d;
   dpl_pi_if lp [NL] ();
   logic [NL-1:0][DW-1:0] loop_out;
   logic [NL-1:0] loop_act;
   logic signed [DW-1:0] ph_meas;
   logic [5:0] dsel;
   logic wr_fire;

   // Splits a byte address into bank and register index
   function automatic logic [5:0] dpl_dec(input logic [7:0] a);
      return {a[7:6], a[5:2]};
   endfunction

   // Keeps the product ratio when one gain moves; saturates on overflow
   function automatic logic [GW-1:0] dpl_rescale(input logic [GW-1:0] o, input logic [GW-1:0] n,
                                                 input logic [GW-1:0] d);
      logic [2*GW-1:0] t;
      t = o * n;
      if (d == '0) begin
         return o;
      end
      t = t / d;
      if (t[2*GW-1:GW] != '0) begin
         return '1;
      end
      return t[GW-1:0];
   endfunction

   // Sign extension of a sample into a bus word
   function automatic logic [31:0] dpl_sx(input logic [DW-1:0] v);
      return {{(32-DW){v[DW-1]}}, v};
   endfunction

   // Phase loop source mux; only this input is selectable
   always_comb begin
      case (s_q.ctrl[C_SEL +: SELW])
         SRC_PHASE: ph_meas = i_lockin_phase;
         SRC_ADC0: ph_meas = i_adc[0];
         SRC_ADC1: ph_meas = i_adc[1];
         SRC_ADC2: ph_meas = i_adc[2];
         SRC_ADC3: ph_meas = i_adc[3];
         default: ph_meas = i_lockin_phase;
      endcase
   end

   assign dsel = dpl_dec(i_avs_address);
   assign wr_fire = (s_q.bus == BS_DONE) && i_avs_write;

   // Bus slave, register writes and modulation timers
   always_comb begin
      logic lsel;
      logic [GW-1:0] wg;
      s_d = s_q;
      lsel = (dsel[5:4] == BANK_PH);
      wg = i_avs_writedata[GW-1:0];
      case (s_q.bus)
         BS_IDLE: begin
            if (i_avs_read || i_avs_write) begin
               s_d.bus = BS_DONE;
               s_d.rdata = '0;
               // Unmapped reads answer zero
               if (i_avs_read && dsel[5:4] == BANK_GLB) begin
                  case (dsel[3:0])
                     IDX_CTRL: s_d.rdata = 32'(s_q.ctrl);
                     IDX_STAT: s_d.rdata = 32'(loop_act);
                     IDX_FSHIFT: s_d.rdata = dpl_sx(s_q.fshift);
                     default: s_d.rdata = '0;
                  endcase
               end else if (i_avs_read && (dsel[5:4] == BANK_AMP || lsel)) begin
                  case (dsel[3:0])
                     IDX_MIN: s_d.rdata = dpl_sx(s_q.mn[lsel]);
                     IDX_MAX: s_d.rdata = dpl_sx(s_q.mx[lsel]);
                     IDX_KP: s_d.rdata = 32'(s_q.kp[lsel]);
                     IDX_KI: s_d.rdata = 32'(s_q.ki[lsel]);
                     IDX_SP: s_d.rdata = dpl_sx(s_q.sp[lsel]);
                     IDX_ALT: s_d.rdata = dpl_sx(s_q.alt[lsel]);
                     IDX_PER: s_d.rdata = s_q.per[lsel];
                     IDX_FIX: s_d.rdata = dpl_sx(s_q.fix[lsel]);
                     IDX_OUT: s_d.rdata = dpl_sx(loop_out[lsel]);
                     default: s_d.rdata = '0;
                  endcase
               end
            end
         end
         BS_DONE: begin
            // Writes land on the edge that completes the transfer
            s_d.bus = BS_IDLE;
            if (i_avs_write && dsel[5:4] == BANK_GLB && dsel[3:0] == IDX_CTRL) begin
               s_d.ctrl = i_avs_writedata[CW-1:0];
            end else if (i_avs_write && (dsel[5:4] == BANK_AMP || lsel)) begin
               case (dsel[3:0])
                  IDX_MIN: s_d.mn[lsel] = i_avs_writedata[DW-1:0];
                  IDX_MAX: s_d.mx[lsel] = i_avs_writedata[DW-1:0];
                  IDX_KP: begin
                     s_d.kp[lsel] = wg;
                     if (s_q.ctrl[C_LOCK + 32'(lsel)]) begin
                        s_d.ki[lsel] = dpl_rescale(s_q.ki[lsel], wg, s_q.kp[lsel]);
                     end
                  end
                  IDX_KI: begin
                     s_d.ki[lsel] = wg;
                     if (s_q.ctrl[C_LOCK + 32'(lsel)]) begin
                        s_d.kp[lsel] = dpl_rescale(s_q.kp[lsel], wg, s_q.ki[lsel]);
                     end
                  end
                  IDX_SP: s_d.sp[lsel] = i_avs_writedata[DW-1:0];
                  IDX_ALT: s_d.alt[lsel] = i_avs_writedata[DW-1:0];
                  IDX_PER: s_d.per[lsel] = i_avs_writedata;
                  IDX_FIX: s_d.fix[lsel] = i_avs_writedata[DW-1:0];
                  default: s_d.fix[lsel] = s_q.fix[lsel];
               endcase
            end
         end
         default: s_d.bus = BS_IDLE;
      endcase
      // Each loop has its own timer; a period of zero toggles every cycle
      for (int l = 0; l < NL; l++) begin
         if (s_q.ctrl[C_MOD + l]) begin
            if (s_q.cnt[l] >= s_q.per[l]) begin
               s_d.cnt[l] = '0;
               s_d.alt_on[l] = ~s_q.alt_on[l];
            end else begin
               s_d.cnt[l] = s_q.cnt[l] + 32'h00000001;
            end
         end else begin
            s_d.cnt[l] = '0;
            s_d.alt_on[l] = 1'b0;
         end
      end
      // Shift against the fixed centre frequency; zero while idle
      if (loop_act[LP_PH]) begin
         s_d.fshift = DW'(loop_out[LP_PH] - s_q.fix[LP_PH]);
      end else begin
         s_d.fshift = '0;
      end
   end

   // State register
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         s_q <= '0;
         s_q.mn <= {NL{RST_MIN}};
         s_q.mx <= {NL{RST_MAX}};
         s_q.per <= {NL{RST_PER}};
      end else begin
         s_q <= s_d;
      end
   end

   // One regulator per loop, wired to its fixed signals
   for (genvar g = 0; g < NL; g++) begin : g_loop
      localparam logic [1:0] BK = 2'(BANK_AMP + g);
      assign lp[g].en = s_q.ctrl[C_EN + g];
      assign lp[g].inv = s_q.ctrl[C_INV + g];
      assign lp[g].kp = s_q.kp[g];
      assign lp[g].ki = s_q.ki[g];
      assign lp[g].sp = s_q.alt_on[g] ? s_q.alt[g] : s_q.sp[g];
      assign lp[g].meas = (g == LP_AMP) ? i_lockin_amplitude : ph_meas;
      assign lp[g].lo = s_q.mn[g];
      assign lp[g].hi = s_q.mx[g];
      assign lp[g].fix = s_q.fix[g];
      assign loop_out[g] = lp[g].out;
      assign loop_act[g] = lp[g].active;

      dpl_pi_core u_core (
         .i_clk(i_clk),
         .i_reset(i_reset),
         .lp(lp[g])
      );

      a_lock_ratio: assert property (
         @(posedge i_clk) disable iff (i_reset)
         wr_fire && dsel == {BK, IDX_KP} && s_q.ctrl[C_LOCK + g]
         |=> s_q.ki[g] == dpl_rescale($past(s_q.ki[g]), $past(i_avs_writedata[GW-1:0]), $past(s_q.kp[g])))
         else $error("gain ratio not kept");

      a_mod_toggle: assert property (
         @(posedge i_clk) disable iff (i_reset)
         s_q.ctrl[C_MOD + g] && s_q.cnt[g] >= s_q.per[g] && !wr_fire
         |=> s_q.alt_on[g] != $past(s_q.alt_on[g]) && s_q.cnt[g] == '0)
         else $error("setpoint modulation did not toggle");
   end

   // Fixed connections toward the generator and z controller
   assign o_excitation_amplitude = loop_out[LP_AMP];
   assign o_excitation_frequency = loop_out[LP_PH];
   assign o_frequency_shift = s_q.fshift;
   assign o_amp_active = loop_act[LP_AMP];
   assign o_phase_active = loop_act[LP_PH];
   assign o_avs_readdata = s_q.rdata;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (s_q.bus != BS_DONE);

   a_phase_src: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_q.ctrl[C_SEL +: SELW] == SRC_ADC2 && $stable(i_adc[2]) ##1 s_q.ctrl[C_EN + LP_PH]
      && s_q.ctrl[C_SEL +: SELW] == SRC_ADC2 |-> lp[LP_PH].meas == i_adc[2])
      else $error("phase loop source mismatch");

   a_fshift_track: assert property (
      @(posedge i_clk) disable iff (i_reset)
      o_phase_active |=> o_frequency_shift == DW'($past(o_excitation_frequency) - $past(s_q.fix[LP_PH])))
      else $error("frequency shift not updated");

   a_phase_start: assert property (
      @(posedge i_clk) disable iff (i_reset)
      !s_q.ctrl[C_EN + LP_PH] [*2] |-> !o_phase_active ##1 o_frequency_shift == '0)
      else $error("phase loop ran without enable");

   a_bus_answer: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_avs_read || i_avs_write) && s_q.bus == BS_IDLE |=> !o_avs_waitrequest)
      else $error("bus answer late");
endmodule

// ---- dpl_pkg.sv ----
// Purpose: Shared constants and types for the dual PI oscillation loops.
// Assumes: One 100 MHz clock; all samples are signed two's complement.
// Notes: Register map is byte addressed, one 32-bit word per register.
package dpl_pkg;
   // Widths and loop count
   localparam int DW = 16;
   localparam int GW = 16;
   localparam int AW = 24;
   localparam int PW = 32;
   localparam int CW = 11;
   localparam int NL = 2;
   localparam int NADC = 4;
   localparam int FRAC = 8;
   localparam int LP_AMP = 0;
   localparam int LP_PH = 1;

   // Control word bit positions, loop index is added to all but C_SEL
   localparam int C_EN = 0;
   localparam int C_INV = 2;
   localparam int C_LOCK = 4;
   localparam int C_MOD = 6;
   localparam int C_SEL = 8;
   localparam int SELW = 3;

   // Address banks and register indices
   localparam logic [1:0] BANK_GLB = 2'h0;
   localparam logic [1:0] BANK_AMP = 2'h1;
   localparam logic [1:0] BANK_PH = 2'h2;
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_STAT = 4'h1;
   localparam logic [3:0] IDX_FSHIFT = 4'h2;
   localparam logic [3:0] IDX_MIN = 4'h0;
   localparam logic [3:0] IDX_MAX = 4'h1;
   localparam logic [3:0] IDX_KP = 4'h2;
   localparam logic [3:0] IDX_KI = 4'h3;
   localparam logic [3:0] IDX_SP = 4'h4;
   localparam logic [3:0] IDX_ALT = 4'h5;
   localparam logic [3:0] IDX_PER = 4'h6;
   localparam logic [3:0] IDX_FIX = 4'h7;
   localparam logic [3:0] IDX_OUT = 4'h8;

   // Reset values
   localparam logic [DW-1:0] RST_MIN = 16'h8000;
   localparam logic [DW-1:0] RST_MAX = 16'h7fff;
   localparam logic [PW-1:0] RST_PER = 32'h000f4240;

   // Phase loop input sources
   localparam logic [SELW-1:0] SRC_PHASE = 3'h0;
   localparam logic [SELW-1:0] SRC_ADC0 = 3'h1;
   localparam logic [SELW-1:0] SRC_ADC1 = 3'h2;
   localparam logic [SELW-1:0] SRC_ADC2 = 3'h3;
   localparam logic [SELW-1:0] SRC_ADC3 = 3'h4;

   // Bus slave states
   typedef enum logic [0:0] {
      BS_IDLE = 1'b0,
      BS_DONE = 1'b1
   } dpl_bus_t;
endpackage

// ---- dpl_pi_if.sv ----
// Purpose: Settings and result of one PI loop between top and core.
// Assumes: Driven by the top, answered by one dpl_pi_core.
// Notes: Gains are unsigned with FRAC fraction bits.
`timescale 1ns/10ps
interface dpl_pi_if;
   import dpl_pkg::*;
   logic en;
   logic inv;
   logic [GW-1:0] kp;
   logic [GW-1:0] ki;
   logic signed [DW-1:0] sp;
   logic signed [DW-1:0] meas;
   logic signed [DW-1:0] lo;
   logic signed [DW-1:0] hi;
   logic signed [DW-1:0] fix;
   logic signed [DW-1:0] out;
   logic active;
   modport ctrl (output en, inv, kp, ki, sp, meas, lo, hi, fix, input out, active);
   modport core (input en, inv, kp, ki, sp, meas, lo, hi, fix, output out, active);
endinterface

// ---- dpl_pi_core.sv ----
// Purpose: One PI regulator with output limits and fixed value when idle.
// Assumes: Settings are stable for a cycle around each change.
// Notes: Integral state is clamped to AW bits to stop wind-up overflow.
`timescale 1ns/10ps
module dpl_pi_core
   import dpl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Loop settings and result
   dpl_pi_if.core lp
);
   typedef struct packed {
      logic signed [AW-1:0] acc;
      logic signed [DW-1:0] out;
      logic act;
   } dpl_pi_st_t;

   localparam logic signed [AW:0] ACC_MAX = (AW+1)'({1'b0, {(AW-1){1'b1}}});
   localparam logic signed [AW:0] ACC_MIN = -ACC_MAX;

   dpl_pi_st_t s_q;
   dpl_pi_st_t s_d;
   logic signed [DW:0] err;
   logic signed [AW:0] acc_sum;
   logic signed [GW+DW+1:0] p_term;
   logic signed [GW+AW:0] i_term;
   logic signed [GW+AW+1:0] y;

   // Error, integral and limited output
   always_comb begin
      s_d = s_q;
      err = (DW+1)'(lp.sp) - (DW+1)'(lp.meas);
      if (lp.inv) begin
         err = -err;
      end
      acc_sum = (AW+1)'(s_q.acc) + (AW+1)'(err);
      if (acc_sum > ACC_MAX) begin
         acc_sum = ACC_MAX;
      end else if (acc_sum < ACC_MIN) begin
         acc_sum = ACC_MIN;
      end
      p_term = $signed({1'b0, lp.kp}) * err;
      i_term = $signed({1'b0, lp.ki}) * acc_sum;
      y = ((GW+AW+2)'(p_term) + (GW+AW+2)'(i_term)) >>> FRAC;
      if (y > (GW+AW+2)'(lp.hi)) begin
         y = (GW+AW+2)'(lp.hi);
      end else if (y < (GW+AW+2)'(lp.lo)) begin
         y = (GW+AW+2)'(lp.lo);
      end
      if (lp.en) begin
         s_d.acc = AW'(acc_sum);
         s_d.out = DW'(y);
         s_d.act = 1'b1;
      end else begin
         // Idle loop hands the fixed setting straight through
         s_d.acc = '0;
         s_d.out = lp.fix;
         s_d.act = 1'b0;
      end
   end

   // State register
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lp.out = s_q.out;
   assign lp.active = s_q.act;

   a_out_in_range: assert property (
      @(posedge i_clk) disable iff (i_reset)
      lp.en && lp.lo <= lp.hi ##1 $stable(lp.lo) && $stable(lp.hi) |-> lp.out >= lp.lo && lp.out <= lp.hi)
      else $error("loop output left its limits");

   a_inv_sign: assert property (
      @(posedge i_clk) disable iff (i_reset)
      lp.en && lp.ki == '0 && lp.kp != '0 && lp.lo <= 0 && lp.hi >= 0 && lp.meas < lp.sp
      |=> ($past(lp.inv) ? lp.out <= 0 : lp.out >= 0))
      else $error("error sign does not follow polarity");

   a_active_flag: assert property (
      @(posedge i_clk) disable iff (i_reset)
      lp.en |=> lp.active)
      else $error("activity flag wrong while enabled");

   a_idle_fixed: assert property (
      @(posedge i_clk) disable iff (i_reset)
      !lp.en |=> lp.out == $past(lp.fix) && !lp.active)
      else $error("idle loop does not show fixed value");
endmodule

// ---- dpl_plant.sv ----
// Purpose: Sample source standing in for the lock-in demodulator and converters.
// Assumes: Levels come from the bench and are registered on i_clk.
// Notes: Open loop only, so the bench knows each measured value exactly.
`timescale 1ns/10ps
module dpl_plant
   import dpl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Levels chosen by the bench
   input wire logic signed [DW-1:0] i_amp_level,
   input wire logic signed [DW-1:0] i_phase_level,
   input wire logic signed [DW-1:0] i_adc_base,
   // Samples toward the loops
   output logic signed [DW-1:0] o_lockin_amplitude,
   output logic signed [DW-1:0] o_lockin_phase,
   output logic [NADC-1:0][DW-1:0] o_adc
);
   // One register stage, like a demodulator output; channels differ by 16 so a wrong pick shows
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_lockin_amplitude <= '0;
         o_lockin_phase <= '0;
         o_adc <= '0;
      end else begin
         o_lockin_amplitude <= i_amp_level;
         o_lockin_phase <= i_phase_level;
         for (int k = 0; k < NADC; k++) begin
            o_adc[k] <= i_adc_base + DW'((k + 1) * 16);
         end
      end
   end
endmodule

// ---- tb_dpl_loops.sv ----
// Purpose: Self-checking bench for the dual loop block over its register bus.
// Assumes: Answer to each bus access comes one cycle after it is seen.
// Notes: Gains of 0x100 mean 1.0, so expected outputs are plain sums.
`timescale 1ns/10ps
module tb_dpl_loops;
   import dpl_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic signed [DW-1:0] amp_lvl = 16'h0;
   logic signed [DW-1:0] ph_lvl = 16'h0;
   logic signed [DW-1:0] adc_base = 16'h0;
   logic signed [DW-1:0] lockin_amp, lockin_ph, o_excitation_amplitude, o_excitation_frequency, o_frequency_shift;
   logic [NADC-1:0][DW-1:0] adc;
   logic o_amp_active, o_phase_active;
   int bad_count = 0;
   int total_checks = 0;
   logic [31:0] v;

   dpl_plant u_plant (.i_clk(i_clk), .i_reset(i_reset), .i_amp_level(amp_lvl), .i_phase_level(ph_lvl),
      .i_adc_base(adc_base), .o_lockin_amplitude(lockin_amp), .o_lockin_phase(lockin_ph), .o_adc(adc));
   dpl_loops DUT (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_lockin_amplitude(lockin_amp), .i_lockin_phase(lockin_ph),
      .i_adc(adc), .o_excitation_amplitude(o_excitation_amplitude), .o_excitation_frequency(o_excitation_frequency),
      .o_frequency_shift(o_frequency_shift), .o_amp_active(o_amp_active), .o_phase_active(o_phase_active));

   // 100 MHz clock
   initial begin
      forever #5 i_clk = ~i_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t register got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t port got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is seen low, released only after that edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      i_avs_writedata <= d;
      // Waitrequest and read data are seen as they stand at each rising edge; only the watchdog ends a hang
      do begin
         @(posedge i_clk);
      end while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   // Plant stage plus loop stage plus shift stage, with margin
   task automatic settle();
      repeat (6) @(negedge i_clk);
   endtask

   function automatic logic [15:0] pick(input logic sel);
      return sel ? o_excitation_frequency : o_excitation_amplitude;
   endfunction

   task automatic t_reset();
      bus(1'b0, 8'h40, 32'h0, v); chk_reg(v, 32'hffff8000);
      bus(1'b0, 8'h84, 32'h0, v); chk_reg(v, 32'h00007fff);
      bus(1'b0, 8'h58, 32'h0, v); chk_reg(v, 32'h000f4240);
      bus(1'b0, 8'hfc, 32'h0, v); chk_reg(v, 32'h0);
      chk_val({15'h0, o_amp_active}, 16'h0);
      chk_val(o_frequency_shift, 16'h0);
      $display("reset test done");
   endtask

   task automatic t_fixed();
      wr(8'h5c, 32'h0123);
      wr(8'h9c, 32'h0456);
      wr(8'h60, 32'h7777);
      settle();
      chk_val(o_excitation_amplitude, 16'h0123);
      chk_val(o_excitation_frequency, 16'h0456);
      chk_val(o_frequency_shift, 16'h0);
      bus(1'b0, 8'h60, 32'h0, v); chk_reg(v, 32'h0123);
      $display("fixed value test done");
   endtask

   task automatic t_prop();
      amp_lvl <= 16'h0100;
      wr(8'h48, 32'h100);
      wr(8'h50, 32'h200);
      wr(8'h00, 32'h1);
      settle();
      chk_val({15'h0, o_amp_active}, 16'h1);
      chk_val(o_excitation_amplitude, 16'h0100);
      chk_val(o_excitation_frequency, 16'h0456);
      wr(8'h44, 32'h80);
      settle();
      chk_val(o_excitation_amplitude, 16'h0080);
      wr(8'h00, 32'h5);
      settle();
      chk_val(o_excitation_amplitude, 16'hff00);
      wr(8'h40, 32'hffc0);
      settle();
      chk_val(o_excitation_amplitude, 16'hffc0);
      wr(8'h40, 32'h8000);
      wr(8'h44, 32'h7fff);
      wr(8'h00, 32'h0);
      settle();
      chk_val({15'h0, o_amp_active}, 16'h0);
      chk_val(o_excitation_amplitude, 16'h0123);
      $display("proportional and limit test done");
   endtask

   task automatic t_phase();
      logic [15:0] m;
      @(posedge i_clk);
      ph_lvl <= 16'h0040;
      adc_base <= 16'h0040;
      wr(8'h88, 32'h100);
      wr(8'h90, 32'h0);
      for (int s = 0; s < 5; s++) begin
         wr(8'h00, (s << 8) | 32'h2);
         settle();
         m = 16'h0040 + 16'(s * 16);
         chk_val(o_excitation_frequency, 16'h0 - m);
         chk_val(o_frequency_shift, 16'h0 - m - 16'h0456);
         bus(1'b0, 8'h04, 32'h0, v); chk_reg(v, 32'h2);
      end
      // Phase loop with inverted polarity on the lock-in phase source
      wr(8'h00, 32'h0a);
      settle();
      chk_val(o_excitation_frequency, 16'h0040);
      chk_val({15'h0, o_phase_active}, 16'h1);
      wr(8'h00, 32'h0);
      $display("phase source test done");
   endtask

   task automatic t_integ();
      logic [15:0] a;
      amp_lvl <= 16'h01ff;
      wr(8'h48, 32'h0);
      wr(8'h4c, 32'h100);
      wr(8'h00, 32'h1);
      settle();
      a = o_excitation_amplitude;
      @(negedge i_clk);
      chk_val(o_excitation_amplitude - a, 16'h0001);
      wr(8'h00, 32'h0);
      $display("integral test done");
   endtask

   task automatic t_lock();
      wr(8'h48, 32'h100);
      wr(8'h4c, 32'h40);
      wr(8'h00, 32'h10);
      wr(8'h48, 32'h200);
      bus(1'b0, 8'h4c, 32'h0, v); chk_reg(v, 32'h80);
      wr(8'h4c, 32'h20);
      bus(1'b0, 8'h48, 32'h0, v); chk_reg(v, 32'h80);
      wr(8'h00, 32'h0);
      $display("gain lock test done");
   endtask

   // Cycles between two changes of one output, bounded
   task automatic run_len(input logic sel, output int n);
      logic [15:0] a;
      int w;
      w = 0;
      a = pick(sel);
      while (pick(sel) === a && w < 40) begin
         @(negedge i_clk);
         w++;
      end
      a = pick(sel);
      n = 0;
      while (pick(sel) === a && n < 40) begin
         @(negedge i_clk);
         n++;
      end
   endtask

   task automatic t_mod();
      int n;
      amp_lvl <= 16'h0100;
      ph_lvl <= 16'h0;
      wr(8'h48, 32'h100);
      wr(8'h4c, 32'h0);
      wr(8'h54, 32'h300);
      wr(8'h58, 32'h3);
      wr(8'h94, 32'h20);
      wr(8'h98, 32'h5);
      wr(8'h00, 32'hc3);
      settle();
      run_len(1'b0, n);
      chk_reg(n, 32'd4);
      run_len(1'b1, n);
      chk_reg(n, 32'd6);
      wr(8'h00, 32'h41);
      settle();
      chk_val(o_excitation_frequency, 16'h0456);
      run_len(1'b0, n);
      chk_reg(n, 32'd4);
      wr(8'h00, 32'h0);
      $display("modulation test done");
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      bad_count++;
      conclude();
   end

   initial begin
      repeat (5) @(posedge i_clk);
      i_reset <= 1'b0;
      t_reset();
      t_fixed();
      t_prop();
      t_phase();
      t_integ();
      t_lock();
      t_mod();
      conclude();
   end
endmodule
